//--- hdl/msmux_baudgen.sv
`default_nettype none
module msmux_baudgen #(
    parameter int N_LINES = msmux_pkg::N_LINES,
    parameter int CLK_HZ = msmux_pkg::CLK_HZ
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // per-line settings
    input wire logic [4*N_LINES-1:0] line_speed,
    input wire logic [N_LINES-1:0] rx_clock_on,
    // oversampling enables
    output logic [N_LINES-1:0] tx_baud_tick,
    output logic [N_LINES-1:0] rx_baud_tick
);
    import msmux_pkg::*;

    // slowest rate must fit the counter
    if (CLK_HZ < 1000 || (longint'(CLK_HZ) * 10) / (OVERSAMPLE * 500) > 65535) begin : g_chk
        $error("clock rate out of range for baud divider");
    end

    function automatic logic [15:0] div_of(input logic [3:0] code);
        int b;
        b = msmux_baud_x10(code);
        if (b == 0) begin
            div_of = '0;
        end else begin
            div_of = 16'((longint'(CLK_HZ) * 10 + (OVERSAMPLE * b) / 2) / (OVERSAMPLE * b));
        end
    endfunction

    for (genvar i = 0; i < N_LINES; i++) begin : g_line
        logic [15:0] cnt;
        logic [15:0] div;
        logic tick;
        assign div = div_of(line_speed[4*i +: 4]);
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                cnt <= '0;
                tick <= 1'b0;
            end else if (div == '0) begin
                cnt <= '0;
                tick <= 1'b0;
            end else if (cnt >= div - 1'b1) begin
                cnt <= '0;
                tick <= 1'b1;
            end else begin
                cnt <= cnt + 1'b1;
                tick <= 1'b0;
            end
        end
        // one rate for both directions; receiver gated by its clock enable
        assign tx_baud_tick[i] = tick;
        assign rx_baud_tick[i] = tick && rx_clock_on[i];
    end
endmodule
`default_nettype wire

//--- hdl/msmux_fifo.sv
`default_nettype none
module msmux_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = msmux_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // fill side
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    output logic full,
    // drain side
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic empty
);
    import msmux_pkg::*;
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_push;
    logic do_pop;

    assign do_push = push && !full;
    assign do_pop = pop && !empty;
    assign full = count == (AW+1)'(DEPTH);
    assign empty = count == '0;
    assign head = mem[rd_ptr];

    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            mem[wr_ptr] <= push_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_push && !do_pop) begin
                count <= count + 1'b1;
            end else if (do_pop && !do_push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- hdl/msmux_pkg.sv
`default_nettype none
package msmux_pkg;
    localparam int N_LINES = 8;
    localparam int LINE_W = 3;
    localparam int CHAR_W = 8;
    localparam int WORD_W = 16;
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CLR_TIME_NS = 15000;
    localparam int CLR_CYCLES = CLR_TIME_NS / CLK_PERIOD_NS;
    localparam int SCAN_GAP_NS = 1900;
    localparam int SCAN_GAP_CYCLES = (SCAN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH = 64;
    localparam int ALARM_ENTRIES = 16;
    localparam int OVERSAMPLE = 16;
    // control/status word fields
    localparam int CSR_LOOP = 3;
    localparam int CSR_CLR = 4;
    localparam int CSR_SCAN = 5;
    localparam int CSR_RIE = 6;
    localparam int CSR_RX_CHAR_AVAILABLE = 7;
    localparam int CSR_TXLINE_LSB = 8;
    localparam int CSR_SAE = 12;
    localparam int CSR_ALARM = 13;
    localparam int CSR_TIE = 14;
    localparam int CSR_TX_LINE_READY = 15;
    // receive word fields
    localparam int RB_LINE_LSB = 8;
    localparam int RB_PERR = 12;
    localparam int RB_FERR = 13;
    localparam int RB_OVRN = 14;
    localparam int RB_VALID = 15;
    // line parameter word fields
    localparam int LP_LINE_LSB = 0;
    localparam int LP_LEN_LSB = 3;
    localparam int LP_STOP = 5;
    localparam int LP_PAR = 6;
    localparam int LP_ODD = 7;
    localparam int LP_SPEED_LSB = 8;
    localparam int LP_RXON = 12;
    // stop length in half units
    localparam logic [2:0] STOP_HALVES_ONE = 3'h2;
    localparam logic [2:0] STOP_HALVES_ONE_HALF = 3'h3;
    localparam logic [2:0] STOP_HALVES_TWO = 3'h4;
    localparam logic [1:0] LEN_5BIT = 2'h0;

    typedef enum logic [1:0] {
        MSMUX_SCAN_HUNT = 2'b00,
        MSMUX_SCAN_READY = 2'b01,
        MSMUX_SCAN_GAP = 2'b11
    } msmux_scan_t;

    // baud rate times ten, zero for the unused code
    function automatic int msmux_baud_x10(input logic [3:0] code);
        case (code)
            4'h0: msmux_baud_x10 = 500;
            4'h1: msmux_baud_x10 = 750;
            4'h2: msmux_baud_x10 = 1100;
            4'h3: msmux_baud_x10 = 1345;
            4'h4: msmux_baud_x10 = 1500;
            4'h5: msmux_baud_x10 = 3000;
            4'h6: msmux_baud_x10 = 6000;
            4'h7: msmux_baud_x10 = 12000;
            4'h8: msmux_baud_x10 = 18000;
            4'h9: msmux_baud_x10 = 20000;
            4'hA: msmux_baud_x10 = 24000;
            4'hB: msmux_baud_x10 = 36000;
            4'hC: msmux_baud_x10 = 48000;
            4'hD: msmux_baud_x10 = 72000;
            4'hE: msmux_baud_x10 = 96000;
            default: msmux_baud_x10 = 0;
        endcase
    endfunction
endpackage
`default_nettype wire

//--- hdl/msmux_top.sv
// Overview of operation
// - loopback bit turns every transmitter output into its receiver input; resets clear it.
// - writing soft clear runs a 15 us reset; bit reads one meanwhile.
// - scan enable starts the scanner feeding receivers and transmitters; resets clear it.
// - receive interrupt enable gates receive requests; resets clear it.
// - receive-available tracks the fifo output; interrupts only with enable and no alarm mode.
// - transmit line field names the ready line; returns to line 0 on resets.
// - transmit-ready set for an enabled loadable line, cleared on load, 1.9 us gap.
// - transmit interrupt enable requests an interrupt while transmit-ready is set.
// - alarm enable swaps receive-available interrupts for alarm interrupts after 16 entries.
// - alarm flag sets after 16 entries, clears on read; re-arms after emptying.
// - receive low byte carries the character with unused high bits zero.
// - receive word carries the three-bit line number of each character.
// - receive word flags parity error; parity bit never stored.
// - overrun flags a pending character replaced before reaching the fifo.
// - valid bit set only for a real fifo character; resets clear it.
// - line parameter write applies to the line its select field names.
// - length code 0..3 selects 5..8 data bits, parity excluded.
// - stop bit gives one unit, or two, or 1.5 with 5-bit characters.
// - parity enable covers both directions; odd select only matters when enabled.
// - speed field sets one rate for transmitter and receiver.
// - receiver-on bit starts that line's receiver clock; resets stop all.
// - speed codes map to 50 through 9600 baud; code 15 unused.
// - every receive word read pops the fifo, except a read while the fifo is empty.
`default_nettype none
module msmux_top #(
    parameter int N_LINES = msmux_pkg::N_LINES,
    parameter int CLK_HZ = msmux_pkg::CLK_HZ
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // control/status word
    input wire logic csr_write,
    input wire logic [msmux_pkg::WORD_W-1:0] csr_wdata,
    output logic [msmux_pkg::WORD_W-1:0] csr_rdata,
    // receive word read, line parameter write
    input wire logic receive_fifo_word_read,
    output logic [msmux_pkg::WORD_W-1:0] receive_fifo_word_rdata,
    input wire logic lpr_write,
    input wire logic [msmux_pkg::WORD_W-1:0] lpr_wdata,
    // interrupt requests
    output logic rx_irq,
    output logic tx_irq,
    // line engines: serial path
    output logic uart_clear,
    output logic scan_enable,
    input wire logic [N_LINES-1:0] line_txd,
    input wire logic [N_LINES-1:0] line_pin_rxd,
    output logic [N_LINES-1:0] line_rxd_to_uart,
    // line engines: received characters
    input wire logic [N_LINES-1:0] rx_char_done,
    input wire logic [msmux_pkg::CHAR_W*N_LINES-1:0] rx_char_data,
    input wire logic [N_LINES-1:0] rx_parity_err,
    input wire logic [N_LINES-1:0] rx_frame_err,
    // line engines: transmit side
    input wire logic [N_LINES-1:0] tx_holding_empty,
    input wire logic [N_LINES-1:0] tx_line_enable_mask,
    input wire logic tx_char_load,
    // line engines: per-line format
    output logic [2*N_LINES-1:0] line_char_len,
    output logic [3*N_LINES-1:0] line_stop_halves,
    output logic [N_LINES-1:0] line_parity_en,
    output logic [N_LINES-1:0] line_parity_odd,
    output logic [4*N_LINES-1:0] line_speed,
    output logic [N_LINES-1:0] rx_clock_on,
    output logic [N_LINES-1:0] tx_baud_tick,
    output logic [N_LINES-1:0] rx_baud_tick
);
    import msmux_pkg::*;
    localparam int FW = WORD_W - 1;

    if (N_LINES != (1 << LINE_W)) begin : g_chk
        $error("line count must match the three-bit line fields");
    end

    // soft clear one-shot
    logic clr_busy;
    logic [8:0] clr_cnt;
    logic int_rst;
    assign int_rst = sys_rst || clr_busy;
    assign uart_clear = int_rst;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            clr_busy <= 1'b0;
            clr_cnt <= '0;
        end else if (clr_busy) begin
            clr_cnt <= clr_cnt + 1'b1;
            if (clr_cnt == 9'(CLR_CYCLES - 1)) begin
                clr_busy <= 1'b0;
            end
        end else if (csr_write && csr_wdata[CSR_CLR]) begin
            clr_busy <= 1'b1;
            clr_cnt <= '0;
        end
    end

    // writable control bits
    logic loop_en;
    logic scan_en;
    logic rx_interrupt_enable;
    logic fifo_alarm_enable;
    logic tx_interrupt_enable;

    always_ff @(posedge sys_clk) begin
        if (int_rst) begin
            loop_en <= 1'b0;
            scan_en <= 1'b0;
            rx_interrupt_enable <= 1'b0;
            fifo_alarm_enable <= 1'b0;
            tx_interrupt_enable <= 1'b0;
        end else if (csr_write && !csr_wdata[CSR_CLR]) begin
            loop_en <= csr_wdata[CSR_LOOP];
            scan_en <= csr_wdata[CSR_SCAN];
            rx_interrupt_enable <= csr_wdata[CSR_RIE];
            fifo_alarm_enable <= csr_wdata[CSR_SAE];
            tx_interrupt_enable <= csr_wdata[CSR_TIE];
        end
    end

    assign scan_enable = scan_en;
    assign line_rxd_to_uart = loop_en ? line_txd : line_pin_rxd;

    // per-line parameters
    logic [LINE_W-1:0] lp_sel;
    assign lp_sel = lpr_wdata[LP_LINE_LSB +: LINE_W];

    for (genvar i = 0; i < N_LINES; i++) begin : g_param
        logic [1:0] len;
        always_ff @(posedge sys_clk) begin
            if (int_rst) begin
                len <= LEN_5BIT;
                line_parity_en[i] <= 1'b0;
                line_parity_odd[i] <= 1'b0;
                line_speed[4*i +: 4] <= '0;
                rx_clock_on[i] <= 1'b0;
            end else if (lpr_write && lp_sel == LINE_W'(i)) begin
                len <= lpr_wdata[LP_LEN_LSB +: 2];
                line_parity_en[i] <= lpr_wdata[LP_PAR];
                line_parity_odd[i] <= lpr_wdata[LP_PAR] && lpr_wdata[LP_ODD];
                line_speed[4*i +: 4] <= lpr_wdata[LP_SPEED_LSB +: 4];
                rx_clock_on[i] <= lpr_wdata[LP_RXON];
            end
        end
        logic stop_long;
        always_ff @(posedge sys_clk) begin
            if (int_rst) begin
                stop_long <= 1'b0;
            end else if (lpr_write && lp_sel == LINE_W'(i)) begin
                stop_long <= lpr_wdata[LP_STOP];
            end
        end
        assign line_char_len[2*i +: 2] = len;
        assign line_stop_halves[3*i +: 3] = !stop_long ? STOP_HALVES_ONE :
            (len == LEN_5BIT) ? STOP_HALVES_ONE_HALF : STOP_HALVES_TWO;
    end

    msmux_baudgen #(
        .N_LINES(N_LINES),
        .CLK_HZ(CLK_HZ)
    ) u_baud (
        .sys_clk(sys_clk),
        .sys_rst(int_rst),
        .line_speed(line_speed),
        .rx_clock_on(rx_clock_on),
        .tx_baud_tick(tx_baud_tick),
        .rx_baud_tick(rx_baud_tick)
    );

    // high bits beyond the character length read as zero
    function automatic logic [CHAR_W-1:0] mask_char(input logic [CHAR_W-1:0] d,
                                                   input logic [1:0] len);
        mask_char = d & (8'hFF >> (2'h3 - len));
    endfunction

    // pending characters, one per line, taken by a rotating pointer
    logic [N_LINES-1:0] pend_valid;
    logic [FW-1:0] pend_word [N_LINES];
    logic [LINE_W-1:0] rx_ptr;
    logic fifo_full;
    logic fifo_empty;
    logic fifo_push;
    logic [FW-1:0] fifo_head;
    assign fifo_push = pend_valid[rx_ptr] && !fifo_full;

    always_ff @(posedge sys_clk) begin
        if (int_rst) begin
            rx_ptr <= '0;
        end else begin
            rx_ptr <= rx_ptr + 1'b1;
        end
    end

    for (genvar i = 0; i < N_LINES; i++) begin : g_rx
        logic taken;
        assign taken = fifo_push && rx_ptr == LINE_W'(i);
        always_ff @(posedge sys_clk) begin
            if (int_rst) begin
                pend_valid[i] <= 1'b0;
                pend_word[i] <= '0;
            end else if (rx_char_done[i] && scan_en) begin
                pend_valid[i] <= 1'b1;
                pend_word[i] <= {pend_valid[i] && !taken,
                                 rx_frame_err[i],
                                 rx_parity_err[i],
                                 1'b0,
                                 LINE_W'(i),
                                 mask_char(rx_char_data[CHAR_W*i +: CHAR_W],
                                           line_char_len[2*i +: 2])};
            end else if (taken) begin
                pend_valid[i] <= 1'b0;
            end
        end
    end

    msmux_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .sys_rst(int_rst),
        .push(fifo_push),
        .push_data(pend_word[rx_ptr]),
        .full(fifo_full),
        .pop(receive_fifo_word_read),
        .head(fifo_head),
        .empty(fifo_empty)
    );

    // receive word: low fields keep their value across clears
    always_ff @(posedge sys_clk) begin
        if (receive_fifo_word_read) begin
            receive_fifo_word_rdata[FW-1:0] <= fifo_head;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (int_rst) begin
            receive_fifo_word_rdata[RB_VALID] <= 1'b0;
        end else if (receive_fifo_word_read) begin
            receive_fifo_word_rdata[RB_VALID] <= !fifo_empty;
        end
    end

    logic rx_char_available;
    assign rx_char_available = !fifo_empty;

    // alarm after a burst of entries; re-arms only once drained
    logic alarm;
    logic armed;
    logic [4:0] alarm_cnt;

    always_ff @(posedge sys_clk) begin
        if (int_rst) begin
            alarm <= 1'b0;
            armed <= 1'b1;
            alarm_cnt <= '0;
        end else begin
            if (fifo_push && armed && alarm_cnt == 5'(ALARM_ENTRIES - 1)) begin
                alarm <= 1'b1;
                armed <= 1'b0;
            end else if (receive_fifo_word_read) begin
                alarm <= 1'b0;
            end
            if (fifo_push && armed) begin
                alarm_cnt <= alarm_cnt + 1'b1;
            end else if (!armed && fifo_empty && !alarm) begin
                armed <= 1'b1;
                alarm_cnt <= '0;
            end
        end
    end

    assign rx_irq = rx_interrupt_enable && (fifo_alarm_enable ? alarm : rx_char_available);

    // transmit scanner
    msmux_scan_t scan_state;
    logic tx_line_ready;
    logic [LINE_W-1:0] tx_line;
    logic [5:0] gap_cnt;
    logic [N_LINES-1:0] tx_cand;
    logic found;
    logic [LINE_W-1:0] found_line;
    assign tx_cand = tx_holding_empty & tx_line_enable_mask;

    // rotating priority starting after the last served line
    always_comb begin
        logic [LINE_W-1:0] k;
        found = 1'b0;
        found_line = tx_line;
        k = tx_line;
        for (int j = 1; j <= N_LINES; j++) begin
            k = tx_line + LINE_W'(j);
            if (!found && tx_cand[k]) begin
                found = 1'b1;
                found_line = k;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (int_rst) begin
            scan_state <= MSMUX_SCAN_HUNT;
            tx_line_ready <= 1'b0;
            tx_line <= '0;
            gap_cnt <= '0;
        end else if (!scan_en) begin
            scan_state <= MSMUX_SCAN_HUNT;
            tx_line_ready <= 1'b0;
        end else begin
            case (scan_state)
                MSMUX_SCAN_HUNT: begin
                    if (found) begin
                        tx_line_ready <= 1'b1;
                        tx_line <= found_line;
                        scan_state <= MSMUX_SCAN_READY;
                    end
                end
                MSMUX_SCAN_READY: begin
                    if (tx_char_load) begin
                        tx_line_ready <= 1'b0;
                        gap_cnt <= '0;
                        scan_state <= MSMUX_SCAN_GAP;
                    end
                end
                MSMUX_SCAN_GAP: begin
                    // hold off so the loaded line's buffer status settles
                    gap_cnt <= gap_cnt + 1'b1;
                    if (gap_cnt == 6'(SCAN_GAP_CYCLES - 1)) begin
                        scan_state <= MSMUX_SCAN_HUNT;
                    end
                end
                default: scan_state <= MSMUX_SCAN_HUNT;
            endcase
        end
    end

    assign tx_irq = tx_interrupt_enable && tx_line_ready;

    // status readback, one cycle behind the state
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            csr_rdata <= '0;
        end else begin
            csr_rdata <= '0;
            csr_rdata[CSR_LOOP] <= loop_en;
            csr_rdata[CSR_CLR] <= clr_busy;
            csr_rdata[CSR_SCAN] <= scan_en;
            csr_rdata[CSR_RIE] <= rx_interrupt_enable;
            csr_rdata[CSR_RX_CHAR_AVAILABLE] <= rx_char_available;
            csr_rdata[CSR_TXLINE_LSB +: LINE_W] <= tx_line;
            csr_rdata[CSR_SAE] <= fifo_alarm_enable;
            csr_rdata[CSR_ALARM] <= alarm;
            csr_rdata[CSR_TIE] <= tx_interrupt_enable;
            csr_rdata[CSR_TX_LINE_READY] <= tx_line_ready;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_clr_run;
        ##299 clr_busy ##1 !clr_busy;
    endsequence

    chk_clr_oneshot: assert property ($rose(clr_busy) |-> s_clr_run)
        else $error("soft clear length wrong");
    chk_loop_route: assert property (loop_en |-> line_rxd_to_uart == line_txd)
        else $error("loopback not routed");
    chk_scan_off: assert property (!scan_en && !clr_busy |=> !tx_line_ready)
        else $error("ready without scan");
    chk_alarm_mode: assert property (fifo_alarm_enable && !alarm |-> !rx_irq)
        else $error("receive irq in alarm mode");
    chk_tx_gap: assert property (tx_line_ready && tx_char_load && !int_rst |=> !tx_line_ready [*8])
        else $error("transmit ready too soon");
    chk_tx_irq: assert property (tx_irq |-> tx_line_ready && tx_interrupt_enable)
        else $error("transmit irq without ready");
    chk_valid_empty: assert property (receive_fifo_word_read && fifo_empty && !int_rst
        |=> !receive_fifo_word_rdata[RB_VALID])
        else $error("valid on empty read");
    chk_param_apply: assert property (lpr_write && !int_rst && lpr_wdata[2:0] == 3'h0
        |=> line_speed[3:0] == $past(lpr_wdata[11:8]))
        else $error("parameters not applied");
endmodule
`default_nettype wire

//--- verification/msmux_line_model.sv
`default_nettype none
module msmux_line_model (
    // clock
    input wire logic sys_clk,
    // received characters
    output logic [7:0] rx_char_done,
    output logic [63:0] rx_char_data,
    output logic [7:0] rx_parity_err,
    output logic [7:0] rx_frame_err,
    // transmit side
    output logic [7:0] tx_holding_empty
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rx_char_done = 8'h00;
        rx_char_data = 64'h0;
        rx_parity_err = 8'h00;
        rx_frame_err = 8'h00;
        tx_holding_empty = 8'hFF;
    end
    // data and flags invert after the pulse so a late sample never matches
    task automatic send(input int ln, input logic [7:0] d, input logic pe, input logic fe);
        @(posedge sys_clk);
        rx_char_done[ln] <= 1'b1;
        rx_char_data[8*ln+:8] <= d;
        rx_parity_err[ln] <= pe;
        rx_frame_err[ln] <= fe;
        @(posedge sys_clk);
        rx_char_done <= 8'h00;
        rx_char_data <= ~rx_char_data;
        rx_parity_err <= ~rx_parity_err;
        rx_frame_err <= ~rx_frame_err;
    endtask
endmodule
`default_nettype wire

//--- verification/msmux_top_test.sv
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module msmux_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, sys_rst, csr_write, receive_fifo_word_read, lpr_write, tx_char_load;
    logic rx_irq, tx_irq, uart_clear, scan_enable, ov;
    logic [15:0] csr_wdata, csr_rdata, receive_fifo_word_rdata, lpr_wdata, w, line_char_len;
    logic [7:0] line_txd, line_pin_rxd, line_rxd_to_uart, rx_char_done, rx_parity_err;
    logic [7:0] rx_frame_err, tx_holding_empty, tx_line_enable_mask, line_parity_en;
    logic [7:0] line_parity_odd, rx_clock_on, tx_baud_tick, rx_baud_tick;
    logic [63:0] rx_char_data;
    logic [23:0] line_stop_halves;
    logic [31:0] line_speed;
    int error_cnt, checks, cyc, n;
    msmux_top dut (.sys_clk, .sys_rst, .csr_write, .csr_wdata, .csr_rdata, .receive_fifo_word_read,
        .receive_fifo_word_rdata, .lpr_write, .lpr_wdata, .rx_irq, .tx_irq, .uart_clear, .scan_enable,
        .line_txd, .line_pin_rxd, .line_rxd_to_uart, .rx_char_done, .rx_char_data,
        .rx_parity_err, .rx_frame_err, .tx_holding_empty, .tx_line_enable_mask,
        .tx_char_load, .line_char_len, .line_stop_halves, .line_parity_en, .line_parity_odd,
        .line_speed, .rx_clock_on, .tx_baud_tick, .rx_baud_tick);
    msmux_line_model lm (.sys_clk, .rx_char_done, .rx_char_data, .rx_parity_err,
        .rx_frame_err, .tx_holding_empty);
    task automatic end_of_test;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // status snapshot lags the state by one cycle, hence two extra edges
    task automatic csr_wr(input logic [15:0] v);
        @(posedge sys_clk);
        csr_write <= 1'b1;
        csr_wdata <= v;
        @(posedge sys_clk);
        csr_write <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask
    task automatic lpr_wr(input logic [15:0] v);
        @(posedge sys_clk);
        lpr_write <= 1'b1;
        lpr_wdata <= v;
        @(posedge sys_clk);
        lpr_write <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic rb_rd(output logic [15:0] v);
        @(posedge sys_clk);
        receive_fifo_word_read <= 1'b1;
        @(posedge sys_clk);
        receive_fifo_word_read <= 1'b0;
        @(posedge sys_clk);
        #1 v = receive_fifo_word_rdata;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        {csr_write, receive_fifo_word_read, lpr_write, tx_char_load} = 4'h0;
        {csr_wdata, lpr_wdata} = 32'h0;
        {line_txd, line_pin_rxd, tx_line_enable_mask} = 24'h0;
        sys_rst = 1'b1;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        // read-only and unused bits must ignore the write
        csr_wr(16'hFFE8);
        `CHK("csr", 16'h5068, csr_rdata)
        `CHK("scan", 1'b1, scan_enable)
        @(posedge sys_clk);
        line_txd <= 8'h5A;
        line_pin_rxd <= 8'hA5;
        wait_cyc(1);
        `CHK("loop", 8'h5A, line_rxd_to_uart)
        lpr_wr(16'h17EA);
        lpr_wr(16'h00A6);
        lpr_wr(16'h101D);
        `CHK("len2", 2'h1, line_char_len[5:4])
        `CHK("len5", 2'h3, line_char_len[11:10])
        `CHK("stop2", 3'h4, line_stop_halves[8:6])
        `CHK("stop6", 3'h3, line_stop_halves[20:18])
        `CHK("stop5", 3'h2, line_stop_halves[17:15])
        `CHK("par", 8'h04, line_parity_en & 8'h64)
        `CHK("odd", 8'h04, line_parity_odd & 8'h64)
        `CHK("speed2", 4'h7, line_speed[11:8])
        `CHK("rxon", 8'h24, rx_clock_on)
        csr_wr(16'h0060);
        `CHK("noloop", 8'hA5, line_rxd_to_uart)
        lm.send(2, 8'hFF, 1'b1, 1'b0);
        wait_cyc(10);
        lm.send(5, 8'hA5, 1'b0, 1'b1);
        wait_cyc(12);
        `CHK("rx_char_available", 1'b1, csr_rdata[7])
        `CHK("rxirq", 1'b1, rx_irq)
        rb_rd(w);
        `CHK("receive_fifo_word", 16'h923F, w)
        rb_rd(w);
        `CHK("receive_fifo_word", 16'hA5A5, w)
        rb_rd(w);
        `CHK("empty", 1'b0, w[15])
        `CHK("idle", 2'h0, {csr_rdata[7], rx_irq})
        lm.send(2, 8'h41, 1'b0, 1'b0);
        wait_cyc(12);
        csr_wr(16'h1060);
        `CHK("saeirq", 2'h2, {csr_rdata[7], rx_irq})
        @(posedge sys_clk);
        tx_line_enable_mask <= 8'h24;
        csr_wr(16'h4020);
        wait_cyc(10);
        `CHK("tx_line_ready", 8'hC2, csr_rdata[15:8])
        `CHK("txirq", 1'b1, tx_irq)
        @(posedge sys_clk);
        tx_char_load <= 1'b1;
        @(posedge sys_clk);
        tx_char_load <= 1'b0;
        wait_cyc(5);
        `CHK("trdylow", 1'b0, csr_rdata[15])
        wait_cyc(45);
        `CHK("tx_line_ready", 8'hC5, csr_rdata[15:8])
        csr_wr(16'h0010);
        `CHK("clr", 2'h3, {csr_rdata[4], uart_clear})
        wait_cyc(310);
        `CHK("csrclr", 16'h0000, csr_rdata)
        `CHK("lineclr", 24'h0, {line_char_len, rx_clock_on})
        rb_rd(w);
        `CHK("fifoclr", 1'b0, w[15])
        // sixteen entries on rotating lines, spaced so none overruns
        csr_wr(16'h1060);
        for (int k = 0; k < 16; k++) begin
            `CHK("noalarm", 2'h0, {csr_rdata[13], rx_irq})
            lm.send(k % 8, 8'hE0 | 8'(k), 1'b0, 1'b0);
            wait_cyc(9);
        end
        `CHK("alarm", 2'h3, {csr_rdata[13], rx_irq})
        rb_rd(w);
        `CHK("alarmrd", 18'h20000, {w, csr_rdata[13], rx_irq})
        repeat (15) rb_rd(w);
        // five quick characters on one line: the pointer cannot store them all
        repeat (5) lm.send(3, 8'h11, 1'b0, 1'b0);
        wait_cyc(9);
        ov = 1'b0;
        rb_rd(w);
        while (w[15]) begin
            ov |= w[14];
            rb_rd(w);
        end
        `CHK("overrun", 1'b1, ov)
        // 9600 baud at 16x from 20 MHz rounds to 130 cycles per tick
        lpr_wr(16'h0E03);
        ov = 1'b0;
        while (!tx_baud_tick[3]) begin
            wait_cyc(1);
        end
        do begin
            ov |= rx_baud_tick[3];
            wait_cyc(1);
            n++;
        end while (!tx_baud_tick[3]);
        `CHK("baud", 130, n)
        `CHK("rxoff", 1'b0, ov)
        end_of_test();
    end
endmodule
`undef CHK
`default_nettype wire
